// ### rtl/timer8_pkg.sv
// timer8_pkg: register map, field positions, modes and prescale codes
// assumes: shared by the timer top and its two leaf modules
package timer8_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_COUNT = 3'h1;
    localparam logic [2:0] ADDR_COMPARE = 3'h2;
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h3;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h4;
    localparam logic [2:0] ADDR_PIN_DIR = 3'h5;
    // ----------------------------------------
    // control fields
    // ----------------------------------------
    localparam int FORCE_BIT = 7;
    localparam int WAVE_LO_BIT = 6;
    localparam int MODE_HI_BIT = 5;
    localparam int MODE_LO_BIT = 4;
    localparam int WAVE_HI_BIT = 3;
    localparam int PRESC_HI_BIT = 2;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    // irq status bits
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_CMP_BIT = 1;
    // ----------------------------------------
    // modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        WAVE_NORMAL = 2'b00,
        WAVE_PHASE_PWM = 2'b01,
        WAVE_CLEAR_ON_MATCH = 2'b10,
        WAVE_FAST_PWM = 2'b11
    } wave_mode_t;
    typedef enum logic [1:0] {
        OUT_OFF = 2'b00,
        OUT_TOGGLE = 2'b01,
        OUT_CLEAR = 2'b10,
        OUT_SET = 2'b11
    } out_mode_t;
    // prescale divide ratios for codes 010..111
    localparam int DIV_8 = 8;
    localparam int DIV_32 = 32;
    localparam int DIV_64 = 64;
    localparam int DIV_128 = 128;
    localparam int DIV_256 = 256;
    localparam int DIV_1024 = 1024;
    localparam int PRESC_WIDTH = 10;
endpackage

// ### rtl/timer8_prescaler.sv
// timer8_prescaler: free-running divider giving one-cycle timer ticks
// assumes: the source clock is clk itself; select comes from a register
`timescale 1ns/10ps
`default_nettype none
module timer8_prescaler (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] sel,
    output logic tick
);
    import timer8_pkg::*;

    logic [PRESC_WIDTH-1:0] div_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // tick when all low bits of the divider are ones
    function automatic logic hit(input logic [PRESC_WIDTH-1:0] v,
                                 input int n);
        logic [PRESC_WIDTH-1:0] m;
        m = PRESC_WIDTH'(n - 1);
        return (v & m) == m;
    endfunction

    always_comb begin
        unique case (sel) // RQ13
            3'h0: tick = 1'b0;
            3'h1: tick = 1'b1;
            3'h2: tick = hit(div_q, DIV_8);
            3'h3: tick = hit(div_q, DIV_32);
            3'h4: tick = hit(div_q, DIV_64);
            3'h5: tick = hit(div_q, DIV_128);
            3'h6: tick = hit(div_q, DIV_256);
            3'h7: tick = hit(div_q, DIV_1024);
        endcase
    end
endmodule
`default_nettype wire

// ### rtl/timer8_wave_out.sv
// timer8_wave_out: compare output level for all four waveform modes
// assumes: match, top and force strobes are one-cycle pulses from top
`timescale 1ns/10ps
`default_nettype none
module timer8_wave_out (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] wave_mode,
    input wire logic [1:0] out_mode,
    input wire logic match,
    input wire logic at_top,
    input wire logic counting_up,
    input wire logic force_cmp,
    output logic level
);
    import timer8_pkg::*;

    wave_mode_t wm;
    out_mode_t om;
    assign wm = wave_mode_t'(wave_mode);
    assign om = out_mode_t'(out_mode);

    logic level_d;

    always_comb begin
        level_d = level;
        unique case (wm)
            WAVE_NORMAL, WAVE_CLEAR_ON_MATCH: begin
                if (match || force_cmp) begin // RQ1 RQ9
                    unique case (om)
                        OUT_OFF: level_d = level;
                        OUT_TOGGLE: level_d = ~level;
                        OUT_CLEAR: level_d = 1'b0;
                        OUT_SET: level_d = 1'b1;
                    endcase
                end
            end
            WAVE_FAST_PWM: begin
                // top action after match so top wins when both hit
                if (om[1]) begin // RQ10
                    if (match) begin
                        level_d = om[0];
                    end
                    if (at_top) begin
                        level_d = ~om[0];
                    end
                end
            end
            WAVE_PHASE_PWM: begin
                if (om[1] && match) begin // RQ11
                    level_d = counting_up ? om[0] : ~om[0];
                end
                // top arrives here only while compare sits at top
                if (om[1] && at_top) begin // RQ12
                    level_d = ~om[0];
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            level <= 1'b0;
        end else begin
            level <= level_d;
        end
    end
endmodule
`default_nettype wire

// ### rtl/timer8_waveform_control.sv
// timer8_waveform_control: 8-bit timer with one compare output
// assumes: single clock, plain register port with one-cycle read data
//
// Function
// RQ1 - forcing compare in non-PWM modes applies the output action at once
// RQ2 - a forced compare raises no interrupt and never clears the counter
// RQ3 - the force bit always reads back as zero
// RQ4 - software writes force bit as zero while a PWM mode is selected
// RQ5 - control bits 6 and 3 select the waveform mode
// RQ6 - each mode sets top, compare update time and overflow point
// RQ7 - any nonzero output mode hands the pin to the compare output
// RQ8 - software must set the pin direction to output for a waveform
// RQ9 - non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match
// RQ10 - fast PWM: 10 clear on match set at top, 11 inverse
// RQ11 - phase PWM: 10 clear up-match, set down-match; 11 inverse
// RQ12 - PWM with compare at top and upper bit set: ignore match, act at top
// RQ13 - prescale select: stop, undivided, or divided by 8 to 1024
// RQ14 - the counter is directly readable and writable
// RQ15 - a counter write suppresses the compare match on the next tick
// RQ16 - compare value is matched continuously for interrupt and waveform
// RQ17 - fast PWM counts bottom to max then restarts at bottom
// RQ18 - phase PWM counts up to max then down, holding max one tick
// RQ19 - normal mode wraps from max to zero and sets the overflow flag
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
module timer8_waveform_control (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic port_out,
    output logic pin_out,
    output logic pin_oe,
    output logic irq
);
    import timer8_pkg::*;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [6:0] control_q;
    logic [7:0] count_q;
    logic [7:0] compare_q;
    logic [7:0] compare_buf_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_mask_q;
    logic pin_dir_q;
    logic count_up_q;
    logic block_match_q;

    wave_mode_t wave_mode;
    logic [1:0] out_mode;
    logic [2:0] presc_sel;
    logic tick;
    logic is_pwm;
    logic [7:0] top_val;
    logic at_top;
    logic at_max;
    logic raw_match;
    logic match_evt;
    logic wave_match;
    logic overflow_evt;
    logic force_cmp;
    logic wave_level;
    logic wr_control;
    logic wr_count;
    logic wr_compare;
    logic rd_status;
    logic wr_mask;
    logic wr_pin_dir;
    logic wave_top;
    logic [7:0] rd_word;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // one register hit, shared by the write and read decoders
    function automatic logic reg_hit(input logic strobe,
                                     input logic [2:0] a,
                                     input logic [2:0] idx);
        return strobe && (a == idx);
    endfunction

    assign wave_mode = wave_mode_t'({control_q[WAVE_HI_BIT],
                                     control_q[WAVE_LO_BIT]}); // RQ5
    assign out_mode = {control_q[MODE_HI_BIT], control_q[MODE_LO_BIT]};
    assign presc_sel = control_q[PRESC_HI_BIT:0];
    assign is_pwm = (wave_mode == WAVE_FAST_PWM) ||
                    (wave_mode == WAVE_PHASE_PWM);
    assign wr_control = reg_hit(wr_en, addr, ADDR_CONTROL);
    assign wr_count = reg_hit(wr_en, addr, ADDR_COUNT);
    assign wr_compare = reg_hit(wr_en, addr, ADDR_COMPARE);
    assign wr_mask = reg_hit(wr_en, addr, ADDR_IRQ_MASK);
    assign wr_pin_dir = reg_hit(wr_en, addr, ADDR_PIN_DIR);
    assign rd_status = reg_hit(rd_en, addr, ADDR_IRQ_STATUS);
    // force only counts outside PWM; software keeps it low there
    assign force_cmp = wr_control && wdata[FORCE_BIT] && !is_pwm; // RQ1 RQ4

    // ----------------------------------------
    // tick source
    // ----------------------------------------
    // stopping the timer freezes the count, not the divider phase
    timer8_prescaler u_presc (
        .clk(clk),
        .rst(rst),
        .sel(presc_sel),
        .tick(tick)
    );

    // ----------------------------------------
    // top, match and overflow
    // ----------------------------------------
    always_comb begin
        unique case (wave_mode) // RQ6
            WAVE_CLEAR_ON_MATCH: top_val = compare_q;
            default: top_val = COUNT_MAX;
        endcase
    end

    assign at_max = (count_q == COUNT_MAX);
    assign at_top = tick && (count_q == top_val) && !wr_count;
    // continuous comparison, one event per tick of the matching value
    assign raw_match = (count_q == compare_q); // RQ16
    assign match_evt = tick && raw_match && !block_match_q &&
                       !wr_count; // RQ15
    // compare at top with upper mode bit: only the top action applies
    assign wave_match = match_evt &&
                        !(is_pwm && compare_q == COUNT_MAX &&
                          out_mode[1]); // RQ12
    // fast pwm acts at every top; phase pwm only when the ignored
    // match sat at top, so the level still lands on the right side
    assign wave_top = at_top &&
                      (wave_mode != WAVE_PHASE_PWM ||
                       (compare_q == COUNT_MAX && out_mode[1])); // RQ12

    // phase pwm flags bottom, reached from one on the way down
    always_comb begin
        overflow_evt = 1'b0;
        if (tick && !wr_count) begin
            if (wave_mode == WAVE_PHASE_PWM) begin
                overflow_evt = !count_up_q &&
                               (count_q == COUNT_BOTTOM + 8'h01); // RQ6
            end else begin
                overflow_evt = at_max; // RQ19
            end
        end
    end

    // ----------------------------------------
    // counter
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= COUNT_RESET;
        end else if (wr_count) begin
            count_q <= wdata; // RQ14
        end else if (tick) begin
            unique case (wave_mode)
                WAVE_PHASE_PWM: begin
                    if (count_up_q) begin // RQ18
                        count_q <= at_max ? COUNT_MAX - 8'h01
                                          : count_q + 8'h01;
                    end else begin
                        count_q <= (count_q == COUNT_BOTTOM)
                                   ? COUNT_BOTTOM + 8'h01
                                   : count_q - 8'h01;
                    end
                end
                WAVE_CLEAR_ON_MATCH: begin
                    // only a real match clears; a forced one never does
                    count_q <= (count_q == top_val) ? COUNT_BOTTOM
                                                    : count_q + 8'h01; // RQ2
                end
                default: begin
                    count_q <= count_q + 8'h01; // RQ17 RQ19
                end
            endcase
        end
    end

    // ----------------------------------------
    // count direction
    // ----------------------------------------
    // turns at max and bottom, so each end lasts exactly one tick
    always_ff @(posedge clk) begin
        if (rst) begin
            count_up_q <= 1'b1;
        end else if (tick && wave_mode == WAVE_PHASE_PWM) begin
            if (count_up_q && at_max) begin
                count_up_q <= 1'b0; // RQ18
            end else if (!count_up_q && count_q == COUNT_BOTTOM) begin
                count_up_q <= 1'b1;
            end
        end else if (wave_mode != WAVE_PHASE_PWM) begin
            count_up_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // match blocking
    // ----------------------------------------
    // a write blocks the match on the tick that follows it
    always_ff @(posedge clk) begin
        if (rst) begin
            block_match_q <= 1'b0;
        end else if (wr_count) begin
            block_match_q <= 1'b1; // RQ15
        end else if (tick) begin
            block_match_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // control and compare registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            control_q <= CONTROL_RESET[6:0];
        end else if (wr_control) begin
            control_q <= wdata[6:0]; // RQ3
        end
    end

    // readback gives the buffered value, not the live compare
    always_ff @(posedge clk) begin
        if (rst) begin
            compare_buf_q <= COMPARE_RESET;
        end else if (wr_compare) begin
            compare_buf_q <= wdata;
        end
    end

    // PWM modes take the new compare only at top, avoiding glitches
    always_ff @(posedge clk) begin
        if (rst) begin
            compare_q <= COMPARE_RESET;
        end else if (!is_pwm) begin
            compare_q <= wr_compare ? wdata : compare_buf_q; // RQ6
        end else if (at_top) begin
            compare_q <= compare_buf_q; // RQ6
        end
    end

    // ----------------------------------------
    // pin direction
    // ----------------------------------------
    // software owns the direction; the timer never drives it
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_dir_q <= 1'b0;
        end else if (wr_pin_dir) begin
            pin_dir_q <= wdata[0];
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    // mask gates only the line; status bits latch regardless
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask_q <= 2'h0;
        end else if (wr_mask) begin
            irq_mask_q <= wdata[1:0];
        end
    end

    // set wins over the read-clear; forced compare never sets a bit
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_status_q <= 2'h0;
        end else begin
            irq_status_q[IRQ_OVF_BIT] <= overflow_evt ||
                (irq_status_q[IRQ_OVF_BIT] && !rd_status);
            irq_status_q[IRQ_CMP_BIT] <= match_evt ||
                (irq_status_q[IRQ_CMP_BIT] && !rd_status); // RQ2 RQ16
        end
    end

    // a cycle behind status, but the line is a clean flop
    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_q & irq_mask_q);
        end
    end

    // ----------------------------------------
    // waveform and pin
    // ----------------------------------------
    timer8_wave_out u_wave (
        .clk(clk),
        .rst(rst),
        .wave_mode(wave_mode),
        .out_mode(out_mode),
        .match(wave_match),
        .at_top(wave_top),
        .counting_up(count_up_q),
        .force_cmp(force_cmp),
        .level(wave_level)
    );

    // pin follows one cycle behind the wave level
    // port data passes through while the output mode is off
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_out <= (|out_mode) ? wave_level : port_out; // RQ7
            pin_oe <= pin_dir_q; // RQ8
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_comb begin
        unique case (addr)
            ADDR_CONTROL: rd_word = {1'b0, control_q}; // RQ3
            ADDR_COUNT: rd_word = count_q; // RQ14
            ADDR_COMPARE: rd_word = compare_buf_q;
            ADDR_IRQ_STATUS: rd_word = {6'h00, irq_status_q};
            ADDR_IRQ_MASK: rd_word = {6'h00, irq_mask_q};
            ADDR_PIN_DIR: rd_word = {7'h00, pin_dir_q};
            default: rd_word = 8'h00;
        endcase
    end

    // the answer stands one cycle only and reads zero otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rd_en ? rd_word : 8'h00;
        end
    end
endmodule
`default_nettype wire

// ### test/timer8_waveform_control_asserts.sv
// timer8_waveform_control_asserts: port-level checks of the timer
// assumes: bound to the timer top; control is shadowed from bus writes
`timescale 1ns/10ps
`default_nettype none
module timer8_waveform_control_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic port_out,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic irq
);
    import timer8_pkg::*;
    // ----------------------------------------
    // control shadow
    // ----------------------------------------
    logic [7:0] ctl_q;
    logic ctl_wr;
    logic force_np;
    assign ctl_wr = wr_en && addr == ADDR_CONTROL;
    // settings rewritten unchanged with the timer held: only the strobe acts
    assign force_np = ctl_wr && wdata[FORCE_BIT] && !wdata[WAVE_LO_BIT]
        && wdata[6:0] == ctl_q[6:0] && ctl_q[2:0] == 3'h0;
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_q <= 8'h00;
        end else if (ctl_wr) begin
            ctl_q <= wdata;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    sequence s_quiet2;
        !wr_en [*2];
    endsequence
    sequence s_quiet3;
        !wr_en [*3];
    endsequence
    property p_rd_idle;
        !$past(rd_en) |-> rdata == 8'h00;
    endproperty
    property p_force_reads_zero;
        rd_en && addr == ADDR_CONTROL |=> !rdata[FORCE_BIT];
    endproperty
    property p_oe_on;
        (wr_en && addr == ADDR_PIN_DIR && wdata[0]) ##1 s_quiet2 |-> pin_oe;
    endproperty
    property p_port_path;
        !$past(rst) && ctl_q[5:4] == 2'b00 && $past(ctl_q[5:4]) == 2'b00
            |-> pin_out == $past(port_out);
    endproperty
    property p_force_toggle;
        force_np && wdata[5:4] == 2'b01 |-> ##2 pin_out != $past(pin_out);
    endproperty
    property p_force_level;
        force_np && wdata[5] |-> ##2 pin_out == $past(wdata[4], 2);
    endproperty
    property p_force_pwm;
        ctl_wr && wdata[WAVE_LO_BIT]
            && wdata[6:0] == ctl_q[6:0] && ctl_q[2:0] == 3'h0
            |-> ##2 $stable(pin_out);
    endproperty
    property p_force_no_irq;
        (force_np && $past(ctl_q[2:0]) == 3'h0 && !irq) ##1 s_quiet3
            |-> !irq;
    endproperty
    property p_status_clear;
        (rd_en && addr == ADDR_IRQ_STATUS && ctl_q[2:0] == 3'h0
            && $past(ctl_q[2:0], 2) == 3'h0) ##1 s_quiet2 |-> !irq;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside a read answer");
    a_force_reads_zero: assert property (p_force_reads_zero)
        else $error("force bit read back as one");
    a_oe_on: assert property (p_oe_on)
        else $error("pin enable not raised by direction write");
    a_port_path: assert property (p_port_path)
        else $error("pin does not follow port data with output off");
    a_force_toggle: assert property (p_force_toggle)
        else $error("forced toggle did not change the pin");
    a_force_level: assert property (p_force_level)
        else $error("forced clear or set gave wrong pin level");
    a_force_pwm: assert property (p_force_pwm)
        else $error("control rewrite in a pwm mode moved the pin");
    a_force_no_irq: assert property (p_force_no_irq)
        else $error("forced compare raised the interrupt");
    a_status_clear: assert property (p_status_clear)
        else $error("interrupt stayed high after status read");
endmodule
`default_nettype wire

// ### test/timer8_waveform_control_bench.sv
// timer8_waveform_control_bench: register-level tests of the timer
// assumes: checker compiled first; 25 MHz clock, synchronous reset
`timescale 1ns/10ps
`default_nettype none
`define CHK(v, e) begin check_count++; if ((v) !== (e)) begin \
    err_total++; $display("ERROR %0t: got %0h exp %0h", $time, v, e); \
    end end
module timer8_waveform_control_bench;
    import timer8_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic port_out = 1'b0;
    logic [7:0] rdata;
    logic pin_out, pin_oe, irq;
    logic [7:0] v;
    int hi;
    int err_total = 0;
    int check_count = 0;
    // last entry selects phase pwm with the force bit kept low
    logic [7:0] fc [7] = '{8'hA0, 8'h90, 8'hB0, 8'h90, 8'hB8, 8'h98, 8'h60};
    logic ex [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    int dv [8] = '{8, 1, 8, 32, 64, 128, 256, 1024};
    logic [7:0] pc [5] = '{8'h69, 8'h79, 8'h69, 8'h61, 8'h71};
    logic [7:0] pv [5] = '{8'h40, 8'h40, 8'hFF, 8'h40, 8'h40};
    int pe [5] = '{64, 192, 256, 128, 382};

    always #20 clk = ~clk;

    timer8_waveform_control dut (.clk, .rst, .addr, .wdata, .wr_en,
        .rd_en, .rdata, .port_out, .pin_out, .pin_oe, .irq);
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        rd(a);
        `CHK(v, e)
    endtask
    // stop the count and let status and irq settle before status reads
    task automatic halt(input logic [7:0] d);
        wr(ADDR_CONTROL, d);
        repeat (3) @(posedge clk);
    endtask
    task automatic duty(input int n);
        hi = 0;
        repeat (n) begin
            @(posedge clk);
            #1 if (pin_out === 1'b1) hi++;
        end
    endtask
    task automatic end_sim;
        if (err_total == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdc(ADDR_CONTROL, 8'h00);
        rdc(ADDR_COUNT, 8'h00);
        rdc(ADDR_COMPARE, 8'h00);
        wr(3'h6, 8'hFF);
        rdc(3'h6, 8'h00);
        wr(ADDR_PIN_DIR, 8'h01);
        @(posedge clk);
        port_out <= 1'b1;
        repeat (3) @(posedge clk);
        #1 `CHK(pin_oe, 1'b1)
        `CHK(pin_out, 1'b1)
        wr(ADDR_COUNT, 8'h55);
        wr(ADDR_IRQ_MASK, 8'h03);
        foreach (fc[i]) begin
            wr(ADDR_CONTROL, {1'b0, fc[i][6:0]});
            wr(ADDR_CONTROL, fc[i]);
            repeat (2) @(posedge clk);
            #1 `CHK(pin_out, ex[i])
        end
        rdc(ADDR_CONTROL, 8'h60);
        rdc(ADDR_COUNT, 8'h55);
        rdc(ADDR_IRQ_STATUS, 8'h00);
        for (int c = 0; c < 8; c++) begin
            if (c == 1) continue;
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_CONTROL, 8'(c));
            repeat (dv[c] * 4) @(posedge clk);
            halt(8'h00);
            rd(ADDR_COUNT);
            `CHK(c == 0 ? v == 8'h00 : v inside {[3:5]}, 1'b1)
        end
        rd(ADDR_IRQ_STATUS);
        wr(ADDR_COMPARE, 8'h80);
        wr(ADDR_COUNT, 8'hFC);
        wr(ADDR_CONTROL, 8'h01);
        for (int i = 0; i < 8 && irq !== 1'b1; i++) @(posedge clk);
        #1 `CHK(irq, 1'b1)
        halt(8'h00);
        wr(ADDR_IRQ_MASK, 8'h00);
        repeat (3) @(posedge clk);
        #1 `CHK(irq, 1'b0)
        wr(ADDR_IRQ_MASK, 8'h03);
        repeat (3) @(posedge clk);
        #1 `CHK(irq, 1'b1)
        rdc(ADDR_IRQ_STATUS, 8'h01);
        repeat (3) @(posedge clk);
        #1 `CHK(irq, 1'b0)
        // count write lands on the compare value: that match is lost
        wr(ADDR_COUNT, 8'h80);
        wr(ADDR_COMPARE, 8'h05);
        wr(ADDR_CONTROL, 8'h09);
        wr(ADDR_COUNT, 8'h05);
        // stop before the count climbs back to the compare value
        repeat (2) @(posedge clk);
        halt(8'h08);
        rdc(ADDR_IRQ_STATUS, 8'h00);
        wr(ADDR_COUNT, 8'h02);
        wr(ADDR_CONTROL, 8'h09);
        repeat (8) @(posedge clk);
        halt(8'h08);
        rd(ADDR_COUNT);
        `CHK(v <= 8'h05, 1'b1)
        rdc(ADDR_IRQ_STATUS, 8'h02);
        foreach (pc[i]) begin
            wr(ADDR_COMPARE, pv[i]);
            wr(ADDR_CONTROL, pc[i]);
            repeat (600) @(posedge clk);
            duty(pc[i][3] ? 256 : 510);
            `CHK(hi >= pe[i] - 2 && hi <= pe[i] + 2, 1'b1)
        end
        end_sim;
    end
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        end_sim;
    end
endmodule
bind timer8_waveform_control timer8_waveform_control_asserts u_chk (
    .clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .port_out,
    .pin_out, .pin_oe, .irq);
`default_nettype wire
